// ---- include/dpw_pkg.sv ----
// Package for the two-channel 8-bit pulse width modulator.
// Assumes a byte-wide register port with offsets 0x60..0x69.
package dpw_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] DPW_OFF_CTL = 8'h60;
  localparam logic [7:0] DPW_OFF_PRESCALE = 8'h61;
  localparam logic [7:0] DPW_OFF_SCALE_A = 8'h62;
  localparam logic [7:0] DPW_OFF_SCALE_B = 8'h63;
  localparam logic [7:0] DPW_OFF_CNT0 = 8'h64;
  localparam logic [7:0] DPW_OFF_CNT1 = 8'h65;
  localparam logic [7:0] DPW_OFF_PER0 = 8'h66;
  localparam logic [7:0] DPW_OFF_PER1 = 8'h67;
  localparam logic [7:0] DPW_OFF_DTY0 = 8'h68;
  localparam logic [7:0] DPW_OFF_DTY1 = 8'h69;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int DPW_CTL_RUN_LSB = 0;
  localparam int DPW_CTL_LEVEL_LSB = 2;
  localparam int DPW_CTL_PICK_LSB = 4;
  localparam int DPW_CTL_ALIGN_LSB = 6;
  localparam int DPW_PRE_A_LSB = 0;
  localparam int DPW_PRE_B_LSB = 4;
  localparam logic [7:0] DPW_PRE_MASK = 8'h77;
  localparam logic [7:0] DPW_RESET_VAL = 8'h00;
  localparam int DPW_PRE_STAGES = 7;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dpw_bus_req_type;

  typedef struct packed {
    logic [1:0] symmetric_align_bit;
    logic [1:0] scaled_source_pick;
    logic [1:0] start_level_bit;
    logic [1:0] channel_run_bit;
  } dpw_ctl_type;

endpackage : dpw_pkg

// ---- core/dpw_channel.sv ----
// One modulator channel: counter, double-buffered period and duty, output.
// Assumes tick is a one-cycle pulse on clk marking its source clock edge.
`timescale 1ns/1ps
`default_nettype none
module dpw_channel (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Control
  input wire logic run,
  input wire logic level,
  input wire logic align,
  input wire logic tick,
  // Register writes
  input wire logic cnt_wr,
  input wire logic per_wr,
  input wire logic dty_wr,
  input wire logic [7:0] wdata,
  // State
  output logic [7:0] count,
  output logic wave
);
  import dpw_pkg::*;

  logic [7:0] cnt_r, per_buf_r, dty_buf_r, per_act_r, dty_act_r;
  logic down_r, wave_r, armed_r;
  logic last_left, top_cent, end_cent, period_end, step;
  logic [7:0] per_src, dty_src;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  assign step = run && armed_r && tick;
  assign last_left = !align && (cnt_r >= per_act_r - 8'h01);
  assign top_cent = align && !down_r && (cnt_r >= per_act_r);
  assign end_cent = align && down_r && (cnt_r <= 8'h01);
  assign period_end = last_left || end_cent;
  // Disabled channel writes go straight to the active latches
  assign per_src = per_wr ? wdata : per_buf_r;
  assign dty_src = dty_wr ? wdata : dty_buf_r;
  assign count = cnt_r;
  assign wave = wave_r;

  // ----------------------------------------------------------------
  // Counter and output
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cnt_r <= DPW_RESET_VAL;
      per_buf_r <= DPW_RESET_VAL;
      dty_buf_r <= DPW_RESET_VAL;
      per_act_r <= DPW_RESET_VAL;
      dty_act_r <= DPW_RESET_VAL;
      down_r <= 1'b0;
      wave_r <= 1'b0;
      armed_r <= 1'b0;
    end
    else if (ce)
    begin
      if (per_wr)
        per_buf_r <= wdata;
      if (dty_wr)
        dty_buf_r <= wdata;
      // Run bit synchronised to the source clock edge
      if (!run)
        armed_r <= 1'b0;
      else if (tick)
        armed_r <= 1'b1;
      if (cnt_wr)
      begin
        cnt_r <= DPW_RESET_VAL;
        down_r <= 1'b0;
        per_act_r <= per_src;
        dty_act_r <= dty_src;
        wave_r <= level;
      end
      else if (!run)
      begin
        // Count held while disabled; latches follow buffers
        per_act_r <= per_src;
        dty_act_r <= dty_src;
      end
      else if (step)
      begin
        if (period_end)
        begin
          // First cycle after enable may be odd
          cnt_r <= DPW_RESET_VAL;
          down_r <= 1'b0;
          per_act_r <= per_buf_r;
          dty_act_r <= dty_buf_r;
          wave_r <= level;
        end
        else
        begin
          if (top_cent || (align && down_r))
          begin
            cnt_r <= cnt_r - 8'h01;
            down_r <= 1'b1;
          end
          else
            cnt_r <= cnt_r + 8'h01;
          // Duty match flips the level
          if (!align && (cnt_r + 8'h01 == dty_act_r))
            wave_r <= !level;
          else if (align && (cnt_r + 8'h01 == dty_act_r) && !down_r && !top_cent)
            wave_r <= !level;
          else if (align && (cnt_r - 8'h01 == dty_act_r) && (down_r || top_cent))
            wave_r <= level;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  cnt_clear_a: assert property (@(posedge clk) disable iff (rst)
    ce && cnt_wr |=> cnt_r == 8'h00 && !down_r && wave_r == $past(level))
    else $error("counter write did not clear");
  hold_off_a: assert property (@(posedge clk) disable iff (rst)
    ce && !run && !cnt_wr |=> cnt_r == $past(cnt_r))
    else $error("disabled counter moved");
  left_wrap_a: assert property (@(posedge clk) disable iff (rst)
    ce && step && !cnt_wr && !align && cnt_r + 8'h01 >= per_act_r |=> cnt_r == 8'h00)
    else $error("left count failed to wrap");
  cent_top_a: assert property (@(posedge clk) disable iff (rst)
    ce && step && !cnt_wr && top_cent && !end_cent |=> down_r && cnt_r == $past(cnt_r) - 8'h01)
    else $error("center count did not turn");
  buf_live_a: assert property (@(posedge clk) disable iff (rst)
    ce && !run && per_wr && !cnt_wr |=> per_act_r == $past(wdata))
    else $error("disabled period write not direct");
  no_step_a: assert property (@(posedge clk) disable iff (rst)
    ce && run && !armed_r && !cnt_wr |=> cnt_r == $past(cnt_r))
    else $error("counted before sync edge");

endmodule : dpw_channel
`default_nettype wire

// ---- core/dpw_top.sv ----
// Two-channel 8-bit modulator: registers, prescaler, scalers, channels.
// Assumes a synchronous byte register port on the interconnect clock.
//
// Overview of operation
// - Prescaler stops while both channels idle.
// - Output starts on next selected clock edge.
// - First cycle after enable may be irregular.
// - Start level bit sets initial output level.
// - Level, pick and prescale writable any time.
// - Channel 0 uses A/SA, channel 1 B/SB.
// - Pick 0 prescaled clock, 1 scaled.
// - Align bit one gives center alignment.
// - Clock A divides by two to select.
// - Clock B likewise; bits 7,3 read zero.
// - SA is A over twice scale A.
// - SB is B over twice scale B.
// - Scale write reloads its down counter immediately.
// - Down counter pulses at one, then halved.
// - Each channel counter readable without disturbance.
// - Left mode counts zero to period minus one.
// - Center mode counts up then down.
// - Counter write clears, loads latches, sets level.
// - Counter clears at effective period end.
// - Disabled counter holds, resumes from held value.
// - Period, duty double buffered, direct when disabled.
// - Duty match toggles the output.
`timescale 1ns/1ps
`default_nettype none
module dpw_top (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Register port
  input wire dpw_pkg::dpw_bus_req_type bus_req,
  output logic [7:0] rdata,
  // Waveforms
  output logic wave_out_ch0,
  output logic wave_out_ch1
);
  import dpw_pkg::*;

  dpw_ctl_type ctl_r;
  logic [7:0] prescale_r, scale_a_r, scale_b_r, per0_r, per1_r, dty0_r, dty1_r;
  logic [7:0] rdata_r, rdata_nxt;
  logic [DPW_PRE_STAGES-1:0] pre_cnt_r;
  logic [7:0] down_a_r, down_b_r;
  logic half_a_r, half_b_r, wave0_r, wave1_r;
  logic any_run, wr_ctl, wr_pre, wr_sa, wr_sb, wr_c0, wr_c1, wr_p0, wr_p1, wr_d0, wr_d1;
  logic [2:0] sel_a, sel_b;
  logic tick_a, tick_b, pulse_a, pulse_b, tick_sa, tick_sb, tick0, tick1;
  logic [7:0] count0, count1;
  logic wave0, wave1;
  logic [DPW_PRE_STAGES:0] pre_next;
  logic [DPW_PRE_STAGES-1:0] mask_a, mask_b;
  logic [DPW_PRE_STAGES-1:0] gap_a_r, gap_b_r;
  logic seen_a_r, seen_b_r;
  localparam logic [DPW_PRE_STAGES-1:0] DPW_PRE_ONE = DPW_PRE_STAGES'(1);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  assign wr_ctl = bus_req.wr && bus_req.addr == DPW_OFF_CTL;
  assign wr_pre = bus_req.wr && bus_req.addr == DPW_OFF_PRESCALE;
  assign wr_sa = bus_req.wr && bus_req.addr == DPW_OFF_SCALE_A;
  assign wr_sb = bus_req.wr && bus_req.addr == DPW_OFF_SCALE_B;
  assign wr_c0 = bus_req.wr && bus_req.addr == DPW_OFF_CNT0;
  assign wr_c1 = bus_req.wr && bus_req.addr == DPW_OFF_CNT1;
  assign wr_p0 = bus_req.wr && bus_req.addr == DPW_OFF_PER0;
  assign wr_p1 = bus_req.wr && bus_req.addr == DPW_OFF_PER1;
  assign wr_d0 = bus_req.wr && bus_req.addr == DPW_OFF_DTY0;
  assign wr_d1 = bus_req.wr && bus_req.addr == DPW_OFF_DTY1;

  // Reads have no side effects; counter read does not disturb it
  always_comb
  begin
    case (bus_req.addr)
      DPW_OFF_CTL: rdata_nxt = ctl_r;
      DPW_OFF_PRESCALE: rdata_nxt = prescale_r & DPW_PRE_MASK;
      DPW_OFF_SCALE_A: rdata_nxt = scale_a_r;
      DPW_OFF_SCALE_B: rdata_nxt = scale_b_r;
      DPW_OFF_CNT0: rdata_nxt = count0;
      DPW_OFF_CNT1: rdata_nxt = count1;
      DPW_OFF_PER0: rdata_nxt = per0_r;
      DPW_OFF_PER1: rdata_nxt = per1_r;
      DPW_OFF_DTY0: rdata_nxt = dty0_r;
      DPW_OFF_DTY1: rdata_nxt = dty1_r;
      default: rdata_nxt = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ctl_r <= DPW_RESET_VAL;
      prescale_r <= DPW_RESET_VAL;
      scale_a_r <= DPW_RESET_VAL;
      scale_b_r <= DPW_RESET_VAL;
      per0_r <= DPW_RESET_VAL;
      per1_r <= DPW_RESET_VAL;
      dty0_r <= DPW_RESET_VAL;
      dty1_r <= DPW_RESET_VAL;
      rdata_r <= DPW_RESET_VAL;
    end
    else if (ce)
    begin
      // Control and prescale accepted at any time
      if (wr_ctl)
        ctl_r <= bus_req.wdata;
      if (wr_pre)
        prescale_r <= bus_req.wdata & DPW_PRE_MASK;
      if (wr_sa)
        scale_a_r <= bus_req.wdata;
      if (wr_sb)
        scale_b_r <= bus_req.wdata;
      if (wr_p0)
        per0_r <= bus_req.wdata;
      if (wr_p1)
        per1_r <= bus_req.wdata;
      if (wr_d0)
        dty0_r <= bus_req.wdata;
      if (wr_d1)
        dty1_r <= bus_req.wdata;
      if (bus_req.rd)
        rdata_r <= rdata_nxt;
    end
  end
  assign rdata = rdata_r;

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  assign any_run = |ctl_r.channel_run_bit;
  assign sel_a = prescale_r[DPW_PRE_A_LSB +: 3];
  assign sel_b = prescale_r[DPW_PRE_B_LSB +: 3];
  // Carry out of each stage marks a divide-by-2^n edge
  assign pre_next = {1'b0, pre_cnt_r} + {{DPW_PRE_STAGES{1'b0}}, 1'b1};
  // Select n ticks when the low n counter bits are all ones
  assign mask_a = DPW_PRE_STAGES'((8'h01 << sel_a) - 8'h01);
  assign mask_b = DPW_PRE_STAGES'((8'h01 << sel_b) - 8'h01);
  assign tick_a = any_run && ((pre_cnt_r & mask_a) == mask_a);
  assign tick_b = any_run && ((pre_cnt_r & mask_b) == mask_b);

  always_ff @(posedge clk)
  begin
    if (rst)
      pre_cnt_r <= '0;
    else if (ce && any_run)
      pre_cnt_r <= pre_next[DPW_PRE_STAGES-1:0];
  end

  // ----------------------------------------------------------------
  // Scalers: down counter then divide by two
  // ----------------------------------------------------------------
  assign pulse_a = tick_a && (down_a_r == 8'h01 || (down_a_r == 8'h00 && scale_a_r == 8'h01));
  assign pulse_b = tick_b && (down_b_r == 8'h01 || (down_b_r == 8'h00 && scale_b_r == 8'h01));
  // Scaled clock edge is the rising half of the divided clock
  assign tick_sa = pulse_a && !half_a_r;
  assign tick_sb = pulse_b && !half_b_r;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      down_a_r <= DPW_RESET_VAL;
      down_b_r <= DPW_RESET_VAL;
      half_a_r <= 1'b0;
      half_b_r <= 1'b0;
    end
    else if (ce)
    begin
      // Zero loads as 256 by wrapping through 255 down
      if (wr_sa)
        down_a_r <= bus_req.wdata;
      else if (pulse_a)
        down_a_r <= scale_a_r;
      else if (tick_a)
        down_a_r <= down_a_r - 8'h01;
      if (wr_sb)
        down_b_r <= bus_req.wdata;
      else if (pulse_b)
        down_b_r <= scale_b_r;
      else if (tick_b)
        down_b_r <= down_b_r - 8'h01;
      if (pulse_a && !wr_sa)
        half_a_r <= !half_a_r;
      if (pulse_b && !wr_sb)
        half_b_r <= !half_b_r;
    end
  end

  // ----------------------------------------------------------------
  // Clock selection and channels
  // ----------------------------------------------------------------
  assign tick0 = ctl_r.scaled_source_pick[0] ? tick_sa : tick_a;
  assign tick1 = ctl_r.scaled_source_pick[1] ? tick_sb : tick_b;

  dpw_channel u_ch0 (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .run(ctl_r.channel_run_bit[0]),
    .level(ctl_r.start_level_bit[0]),
    .align(ctl_r.symmetric_align_bit[0]),
    .tick(tick0),
    .cnt_wr(wr_c0),
    .per_wr(wr_p0),
    .dty_wr(wr_d0),
    .wdata(bus_req.wdata),
    .count(count0),
    .wave(wave0)
  );

  dpw_channel u_ch1 (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .run(ctl_r.channel_run_bit[1]),
    .level(ctl_r.start_level_bit[1]),
    .align(ctl_r.symmetric_align_bit[1]),
    .tick(tick1),
    .cnt_wr(wr_c1),
    .per_wr(wr_p1),
    .dty_wr(wr_d1),
    .wdata(bus_req.wdata),
    .count(count1),
    .wave(wave1)
  );

  // Registered outputs to the drivers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wave0_r <= 1'b0;
      wave1_r <= 1'b0;
    end
    else if (ce)
    begin
      wave0_r <= wave0;
      wave1_r <= wave1;
    end
  end
  assign wave_out_ch0 = wave0_r;
  assign wave_out_ch1 = wave1_r;

  // ----------------------------------------------------------------
  // Check helpers
  // ----------------------------------------------------------------
  // Cycles since the last prescaled tick; a select write or an idle
  // spell moves the counter phase, so the next gap is not trusted
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      gap_a_r <= '0;
      gap_b_r <= '0;
      seen_a_r <= 1'b0;
      seen_b_r <= 1'b0;
    end
    else if (ce)
    begin
      gap_a_r <= tick_a ? '0 : gap_a_r + DPW_PRE_ONE;
      gap_b_r <= tick_b ? '0 : gap_b_r + DPW_PRE_ONE;
      if (wr_pre || !any_run)
      begin
        seen_a_r <= 1'b0;
        seen_b_r <= 1'b0;
      end
      else
      begin
        if (tick_a)
          seen_a_r <= 1'b1;
        if (tick_b)
          seen_b_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  pre_stop_a: assert property (@(posedge clk) disable iff (rst)
    ce && !any_run |=> pre_cnt_r == $past(pre_cnt_r))
    else $error("prescaler ran while idle");
  pre_res_a: assert property (@(posedge clk) disable iff (rst)
    bus_req.rd && bus_req.addr == DPW_OFF_PRESCALE && ce |=> rdata[7] == 1'b0 && rdata[3] == 1'b0)
    else $error("reserved prescale bits read set");
  scl_load_a: assert property (@(posedge clk) disable iff (rst)
    ce && wr_sa |=> down_a_r == $past(bus_req.wdata))
    else $error("scale A write did not reload");
  half_flip_a: assert property (@(posedge clk) disable iff (rst)
    ce && pulse_a && !wr_sa |=> half_a_r != $past(half_a_r))
    else $error("divide by two stage stuck");

  // Prescaler rates
  pre_run_a: assert property (@(posedge clk) disable iff (rst)
    ce && any_run |=> pre_cnt_r == $past(pre_cnt_r) + DPW_PRE_ONE)
    else $error("prescaler did not run");
  gap_a_rate_a: assert property (@(posedge clk) disable iff (rst)
    ce && tick_a && seen_a_r |-> gap_a_r == mask_a)
    else $error("clock A tick spacing wrong");
  gap_b_rate_a: assert property (@(posedge clk) disable iff (rst)
    ce && tick_b && seen_b_r |-> gap_b_r == mask_b)
    else $error("clock B tick spacing wrong");

  // Scale down counters
  scl_b_load_a: assert property (@(posedge clk) disable iff (rst)
    ce && wr_sb |=> down_b_r == $past(bus_req.wdata))
    else $error("scale B write did not reload");
  reload_a_a: assert property (@(posedge clk) disable iff (rst)
    ce && pulse_a && !wr_sa |=> down_a_r == $past(scale_a_r))
    else $error("scale A counter did not reload");
  reload_b_a: assert property (@(posedge clk) disable iff (rst)
    ce && pulse_b && !wr_sb |=> down_b_r == $past(scale_b_r))
    else $error("scale B counter did not reload");
  down_step_a: assert property (@(posedge clk) disable iff (rst)
    ce && tick_a && !pulse_a && !wr_sa |=> down_a_r == $past(down_a_r) - 8'h01)
    else $error("scale A counter did not step");
  down_b_step_a: assert property (@(posedge clk) disable iff (rst)
    ce && tick_b && !pulse_b && !wr_sb |=> down_b_r == $past(down_b_r) - 8'h01)
    else $error("scale B counter did not step");
  zero_wrap_b_a: assert property (@(posedge clk) disable iff (rst)
    ce && tick_b && !pulse_b && !wr_sb && down_b_r == 8'h00 |=> down_b_r == 8'hFF)
    else $error("zero scale B not full scale");
  half_b_flip_a: assert property (@(posedge clk) disable iff (rst)
    ce && pulse_b && !wr_sb |=> half_b_r != $past(half_b_r))
    else $error("divide by two stage B stuck");

  // Counter reads return the live count
  cnt_read_a: assert property (@(posedge clk) disable iff (rst)
    ce && bus_req.rd && bus_req.addr == DPW_OFF_CNT0 |=> rdata == $past(count0))
    else $error("channel 0 count read wrong");
  cnt1_read_a: assert property (@(posedge clk) disable iff (rst)
    ce && bus_req.rd && bus_req.addr == DPW_OFF_CNT1 |=> rdata == $past(count1))
    else $error("channel 1 count read wrong");

endmodule : dpw_top
`default_nettype wire

// ---- tb/dpw_load_model.sv ----
// Load on a modulator output: driver or pin seen as a sink.
// Assumes clk samples the wave; lengths are in clk cycles.
`timescale 1ns/1ps
`default_nettype none
module dpw_load_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Waveform in
  input wire logic wave,
  // Measurements
  output logic [15:0] period_len,
  output logic [15:0] high_len,
  output logic [15:0] rises
);
  logic [15:0] since_r;
  logic wave_r;

  // Rise to rise gives the period, rise to fall the high time
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      since_r <= 16'h0000;
      wave_r <= 1'b0;
      period_len <= 16'h0000;
      high_len <= 16'h0000;
      rises <= 16'h0000;
    end
    else
    begin
      wave_r <= wave;
      since_r <= since_r + 16'h0001;
      if (wave && !wave_r)
      begin
        period_len <= since_r + 16'h0001;
        since_r <= 16'h0000;
        rises <= rises + 16'h0001;
      end
      if (!wave && wave_r)
        high_len <= since_r + 16'h0001;
    end
  end
endmodule : dpw_load_model
`default_nettype wire

// ---- tb/dpw_top_bench.sv ----
// Self-checking bench for the two-channel modulator.
// Assumes the package and the load model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module dpw_top_bench;
  import dpw_pkg::*;
  logic clk;
  logic rst;
  logic ce;
  dpw_bus_req_type req;
  logic [7:0] rdata;
  logic [1:0] wave;
  logic [15:0] per_len [2];
  logic [15:0] high_len [2];
  logic [15:0] rises [2];
  logic [7:0] lfsr;
  logic [7:0] d;
  int err_count = 0;
  int tests_run = 0;
  int cycles = 0;

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  dpw_top DUT (.clk(clk), .rst(rst), .ce(ce), .bus_req(req), .rdata(rdata),
    .wave_out_ch0(wave[0]), .wave_out_ch1(wave[1]));
  dpw_load_model load0 (.clk(clk), .rst(rst), .wave(wave[0]), .period_len(per_len[0]),
    .high_len(high_len[0]), .rises(rises[0]));
  dpw_load_model load1 (.clk(clk), .rst(rst), .wave(wave[1]), .period_len(per_len[1]),
    .high_len(high_len[1]), .rises(rises[1]));

  function automatic logic [7:0] lfsr_next(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr_next

  // Counts times source division times two in center mode
  function automatic logic [15:0] exp_len(input logic [7:0] n, input logic [15:0] div,
                                          input logic align);
    return {8'h00, n} * div * (align ? 16'h0002 : 16'h0001);
  endfunction : exp_len

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check

  task automatic bus_write(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
    @(posedge clk);
    req <= '0;
  endtask : bus_write

  task automatic bus_read(input logic [7:0] addr, output logic [7:0] data);
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
    @(posedge clk);
    req <= '0;
    @(posedge clk);
    #1 data = rdata;
  endtask : bus_read

  task automatic wave_case(input logic ch, input logic [2:0] pre, input logic pick,
                           input logic [7:0] scale, input logic align, input logic level);
    logic [7:0] per;
    logic [7:0] dty;
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] ctl;
    logic [7:0] lim;
    logic [15:0] div;
    logic [15:0] start;
    int guard;
    lfsr = lfsr_next(lfsr);
    per = 8'h02 + {5'h00, lfsr[2:0]};
    dty = 8'h01 + 8'({4'h0, lfsr[7:4]} % (per - 8'h01));
    lim = align ? per : per - 8'h01;
    div = 16'h0001 << pre;
    if (pick)
      div = div * 16'h0002 * ((scale == 8'h00) ? 16'h0100 : {8'h00, scale});
    ctl = 8'h00;
    ctl[DPW_CTL_RUN_LSB + ch] = 1'b1;
    ctl[DPW_CTL_LEVEL_LSB + ch] = level;
    ctl[DPW_CTL_PICK_LSB + ch] = pick;
    ctl[DPW_CTL_ALIGN_LSB + ch] = align;
    // Alignment only changes while both channels are off
    bus_write(DPW_OFF_CTL, 8'h00);
    bus_write(DPW_OFF_PRESCALE, {1'b0, pre, 1'b0, pre});
    bus_write(ch ? DPW_OFF_SCALE_B : DPW_OFF_SCALE_A, scale);
    bus_write(ch ? DPW_OFF_PER1 : DPW_OFF_PER0, per);
    bus_write(ch ? DPW_OFF_DTY1 : DPW_OFF_DTY0, dty);
    bus_write(ch ? DPW_OFF_CNT1 : DPW_OFF_CNT0, lfsr);
    bus_write(DPW_OFF_CTL, ctl);
    start = rises[ch];
    guard = 0;
    // Counter reads run alongside; the first cycle is skipped as irregular
    while (rises[ch] < start + 16'h0004 && guard < 12000)
    begin
      bus_read(ch ? DPW_OFF_CNT1 : DPW_OFF_CNT0, a);
      check({15'h0000, a > lim}, 16'h0000);
      guard++;
    end
    check(per_len[ch], exp_len(per, div, align));
    check(high_len[ch], exp_len(level ? dty : per - dty, div, align));
    // Clock enable low: the tested channel's pin must not rise
    @(posedge clk);
    ce <= 1'b0;
    repeat (2) @(posedge clk);
    start = rises[ch];
    repeat (40) @(posedge clk);
    check(rises[ch], start);
    ce <= 1'b1;
    bus_write(DPW_OFF_CTL, 8'h00);
    bus_read(ch ? DPW_OFF_CNT1 : DPW_OFF_CNT0, a);
    repeat (20) @(posedge clk);
    bus_read(ch ? DPW_OFF_CNT1 : DPW_OFF_CNT0, b);
    check({8'h00, b}, {8'h00, a});
    bus_write(ch ? DPW_OFF_CNT1 : DPW_OFF_CNT0, ~lfsr);
    bus_read(ch ? DPW_OFF_CNT1 : DPW_OFF_CNT0, b);
    check({8'h00, b}, 16'h0000);
  endtask : wave_case

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : conclude

  // Longest run is the full-scale scaled case, near 14k cycles
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 90000)
    begin
      err_count++;
      conclude();
    end
  end

  initial
  begin
    rst = 1'b1;
    ce = 1'b1;
    req = '0;
    lfsr = 8'h1B;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    for (int a = 16'h60; a <= 16'h69; a++)
    begin
      bus_read(8'(a), d);
      check({8'h00, d}, 16'h0000);
    end
    bus_write(8'h6A, 8'hFF);
    bus_read(8'h6A, d);
    check({8'h00, d}, 16'h0000);
    bus_write(DPW_OFF_PRESCALE, 8'hFF);
    bus_read(DPW_OFF_PRESCALE, d);
    check({8'h00, d}, {8'h00, DPW_PRE_MASK});
    bus_write(DPW_OFF_SCALE_A, lfsr);
    bus_read(DPW_OFF_SCALE_A, d);
    check({8'h00, d}, {8'h00, lfsr});
    bus_write(DPW_OFF_SCALE_B, ~lfsr);
    bus_read(DPW_OFF_SCALE_B, d);
    check({8'h00, d}, {8'h00, ~lfsr});
    for (int i = 0; i < 16; i++)
    begin
      wave_case(i[0], i[3:1], 1'b0, 8'h00, i[2], i[1]);
    end
    for (int i = 0; i < 4; i++)
    begin
      lfsr = lfsr_next(lfsr);
      wave_case(i[0], {2'b00, i[1]} & {3{i != 3}}, 1'b1,
        (i == 3) ? 8'h00 : 8'h01 + {6'h00, lfsr[1:0]}, 1'b0, ~i[0]);
    end
    conclude();
  end
endmodule : dpw_top_bench
`default_nettype wire
